// [common/tcr_pkg.sv]
// Functional notes
// - complete/progress responses echo the sub-command
// - sync length error: expected then received length
// - sync sequence error: expected then received byte
// - sync group error carries bad group word
// - sync ack error carries bad ack word
// - async length error: expected then received length
// - async sequence error: expected then received byte
// - async group error carries bad group word
// - timeout, system, control word, data errors: no payload
// - command failed carries failing sub-command
// - sub-command error carries rejected sub-command
// - set acknowledged by bytes 00h 02h only
// - control 0 no stamp, 1 stamp every tag response
// - stamp order hours minutes seconds hundredths month day year
// - hours 00h-17h, minutes and seconds 00h-3bh
// - hundredths, year 00h-63h; month 01h-0ch; day 01h-1fh
// - query 0003h answered 00h 03h then control byte
// - one stored control governs all tag responses
// - codes classed by upper byte 82h 42h 48h
package tcr_pkg;
    localparam logic [15:0] CMD_SET_APPEND   = 16'h0002;
    localparam logic [15:0] CMD_GET_APPEND   = 16'h0003;
    localparam logic [7:0]  CLASS_SYNC_ERR   = 8'h82;
    localparam logic [7:0]  CLASS_ASYNC_ERR  = 8'h42;
    localparam logic [7:0]  CLASS_ASYNC_OK   = 8'h48;
    localparam logic [7:0]  SUB_COMPLETE     = 8'h00;
    localparam logic [7:0]  SUB_PROGRESS     = 8'h01;
    localparam logic [7:0]  SUB_LEN          = 8'h00;
    localparam logic [7:0]  SUB_SEQ          = 8'h01;
    localparam logic [7:0]  SUB_GROUP        = 8'h03;
    localparam logic [7:0]  SUB_TIMEOUT      = 8'h04;
    localparam logic [7:0]  SUB_FAILED       = 8'h06;
    localparam logic [7:0]  SUB_SYSTEM       = 8'h07;
    localparam logic [7:0]  SUB_SUBCMD       = 8'h08;
    localparam logic [7:0]  SUB_ACK          = 8'h09;
    localparam logic [7:0]  SUB_CTRLWORD     = 8'h0a;
    localparam logic [7:0]  SUB_CMDDATA      = 8'h0b;
    localparam logic        APPEND_RESET     = 1'b0;
    localparam int          FIFO_WIDTH       = 9;
    localparam int          FIFO_DEPTH       = 8;
    localparam int          MAX_BYTES        = 16;
    localparam int          STAMP_BYTES      = 7;
    localparam logic [7:0]  HOUR_MAX         = 8'h17;
    localparam logic [7:0]  MINSEC_MAX       = 8'h3b;
    localparam logic [7:0]  CENT_MAX         = 8'h63;
    localparam logic [7:0]  MONTH_MIN        = 8'h01;
    localparam logic [7:0]  MONTH_MAX        = 8'h0c;
    localparam logic [7:0]  DAY_MIN          = 8'h01;
    localparam logic [7:0]  DAY_MAX          = 8'h1f;

    typedef enum logic [3:0] {
        EV_COMPLETE, EV_PROGRESS, EV_S_LEN, EV_S_SEQ, EV_S_GROUP, EV_S_ACK,
        EV_A_LEN, EV_A_SEQ, EV_A_GROUP, EV_A_TIMEOUT, EV_A_FAILED, EV_A_SYSTEM,
        EV_A_SUBCMD, EV_A_CTRLWORD, EV_A_CMDDATA
    } tcr_event_e;

    typedef struct packed {
        tcr_event_e  kind;
        logic [15:0] word_a;
        logic [15:0] word_b;
    } tcr_event_s;

    typedef struct packed {
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
        logic [7:0] hundredths;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] year;
    } tcr_stamp_s;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } tcr_byte_s;
endpackage

// [hw/tcr_fifo.sv]
`timescale 1ns/1ps
module tcr_fifo
    import tcr_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_comb begin
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// [hw/tcr_stamp_clamp.sv]
`timescale 1ns/1ps
module tcr_stamp_clamp
    import tcr_pkg::*;
(
    input  wire tcr_stamp_s raw,
    output tcr_stamp_s      clean
);
    // out-of-range fields clamp rather than pass garbage to the host
    function automatic logic [7:0] fit(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
        fit = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    always_comb begin
        clean.hours      = fit(raw.hours, 8'h00, HOUR_MAX);
        clean.minutes    = fit(raw.minutes, 8'h00, MINSEC_MAX);
        clean.seconds    = fit(raw.seconds, 8'h00, MINSEC_MAX);
        clean.hundredths = fit(raw.hundredths, 8'h00, CENT_MAX);
        clean.month      = fit(raw.month, MONTH_MIN, MONTH_MAX);
        clean.day        = fit(raw.day, DAY_MIN, DAY_MAX);
        clean.year       = fit(raw.year, 8'h00, CENT_MAX);
    end
endmodule

// [hw/tcr_responder.sv]
`timescale 1ns/1ps
module tcr_responder
    import tcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        cmd_valid,
    input  wire logic [15:0] cmd_word,
    input  wire logic [7:0]  cmd_arg,
    output logic             cmd_ready,
    input  wire logic        evt_valid,
    input  wire tcr_event_s  evt,
    output logic             evt_ready,
    input  wire logic        tag_valid,
    input  wire logic        tag_last,
    input  wire logic [7:0]  tag_data,
    output logic             tag_ready,
    input  wire tcr_stamp_s  time_now,
    output logic             rsp_valid,
    output logic             rsp_last,
    output logic [7:0]       rsp_data,
    input  wire logic        rsp_ready,
    output logic             append_on
);
    typedef enum logic [1:0] {ST_IDLE, ST_MSG, ST_TAG, ST_STAMP} tcr_state_e;

    tcr_state_e          state;
    tcr_state_e          next_state;
    logic [7:0]          buf_q [MAX_BYTES];
    logic [7:0]          next_buf [MAX_BYTES];
    logic [4:0]          len;
    logic [4:0]          next_len;
    logic [4:0]          idx;
    logic [4:0]          next_idx;
    logic                append;
    logic                next_append;
    tcr_stamp_s          stamp;
    tcr_stamp_s          next_stamp;
    tcr_stamp_s          stamp_clean;
    logic [STAMP_BYTES*8-1:0] stamp_flat;
    tcr_byte_s           push_byte;
    logic                push_valid;
    logic                push_ready;
    tcr_byte_s           pop_byte;
    logic                pop_valid;
    logic                pop_ready;
    logic                next_rsp_valid;
    logic                next_rsp_last;
    logic [7:0]          next_rsp_data;

    // code word from class byte and sub-code
    function automatic logic [15:0] code(input logic [7:0] cls, input logic [7:0] sub);
        code = {cls, sub};
    endfunction

    tcr_stamp_clamp u_clamp (
        .raw   (time_now),
        .clean (stamp_clean)
    );

    tcr_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   (push_byte),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (pop_byte),
        .out_valid (pop_valid),
        .out_ready (pop_ready)
    );

    assign stamp_flat = stamp;
    assign cmd_ready  = (state == ST_IDLE);
    assign evt_ready  = (state == ST_IDLE) && !cmd_valid;
    assign tag_ready  = (state == ST_TAG) && push_ready;
    assign append_on  = append;
    // output register stage keeps rsp_valid, rsp_last and rsp_data straight from flops
    assign pop_ready  = !rsp_valid || rsp_ready;

    always_comb begin
        next_state  = state;
        next_len    = len;
        next_idx    = idx;
        next_append = append;
        next_stamp  = stamp;
        push_valid  = 1'b0;
        push_byte   = '0;
        for (int i = 0; i < MAX_BYTES; i++) begin
            next_buf[i] = buf_q[i];
        end
        case (state)
            ST_IDLE: begin
                next_idx = '0;
                if (cmd_valid) begin
                    next_state  = ST_MSG;
                    next_buf[0] = cmd_word[15:8];
                    next_buf[1] = cmd_word[7:0];
                    next_len    = 5'd2;
                    if (cmd_word == CMD_SET_APPEND) begin
                        next_append = cmd_arg[0];
                    end else if (cmd_word == CMD_GET_APPEND) begin
                        next_buf[2] = {7'h00, append};
                        next_len    = 5'd3;
                    end
                end else if (evt_valid) begin
                    next_state = ST_MSG;
                    next_buf[2] = evt.word_a[15:8];
                    next_buf[3] = evt.word_a[7:0];
                    next_buf[4] = evt.word_b[15:8];
                    next_buf[5] = evt.word_b[7:0];
                    next_len   = 5'd4;
                    case (evt.kind)
                        EV_COMPLETE: {next_buf[0], next_buf[1]} =
                            code(CLASS_ASYNC_OK, SUB_COMPLETE);
                        EV_PROGRESS: {next_buf[0], next_buf[1]} =
                            code(CLASS_ASYNC_OK, SUB_PROGRESS);
                        EV_S_LEN: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_SYNC_ERR, SUB_LEN);
                            next_len = 5'd6;
                        end
                        EV_S_SEQ: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_SYNC_ERR, SUB_SEQ);
                            next_buf[2] = evt.word_a[7:0];
                            next_buf[3] = evt.word_b[7:0];
                        end
                        EV_S_GROUP: {next_buf[0], next_buf[1]} =
                            code(CLASS_SYNC_ERR, SUB_GROUP);
                        EV_S_ACK: {next_buf[0], next_buf[1]} =
                            code(CLASS_SYNC_ERR, SUB_ACK);
                        EV_A_LEN: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_LEN);
                            next_len = 5'd6;
                        end
                        EV_A_SEQ: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_SEQ);
                            next_buf[2] = evt.word_a[7:0];
                            next_buf[3] = evt.word_b[7:0];
                        end
                        EV_A_GROUP: {next_buf[0], next_buf[1]} =
                            code(CLASS_ASYNC_ERR, SUB_GROUP);
                        EV_A_FAILED: {next_buf[0], next_buf[1]} =
                            code(CLASS_ASYNC_ERR, SUB_FAILED);
                        EV_A_SUBCMD: {next_buf[0], next_buf[1]} =
                            code(CLASS_ASYNC_ERR, SUB_SUBCMD);
                        EV_A_TIMEOUT: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_TIMEOUT);
                            next_len = 5'd2;
                        end
                        EV_A_SYSTEM: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_SYSTEM);
                            next_len = 5'd2;
                        end
                        EV_A_CTRLWORD: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_CTRLWORD);
                            next_len = 5'd2;
                        end
                        default: begin
                            {next_buf[0], next_buf[1]} = code(CLASS_ASYNC_ERR, SUB_CMDDATA);
                            next_len = 5'd2;
                        end
                    endcase
                end else if (tag_valid) begin
                    next_state = ST_TAG;
                    next_stamp = stamp_clean; // single capture
                end
            end
            ST_MSG: begin
                push_valid = 1'b1;
                push_byte  = '{last: (idx == len - 5'd1), data: buf_q[idx[3:0]]};
                if (push_ready) begin
                    next_idx = idx + 5'd1;
                    if (idx == len - 5'd1) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_TAG: begin
                // the append flag is sampled per byte; it only changes in idle
                push_valid = tag_valid;
                push_byte  = '{last: tag_last && !append, data: tag_data};
                if (tag_valid && push_ready && tag_last) begin
                    next_idx   = '0;
                    next_state = append ? ST_STAMP : ST_IDLE;
                end
            end
            ST_STAMP: begin
                push_valid = 1'b1;
                // msb-first flatten gives hours first, year last
                push_byte  = '{last: (idx == 5'(STAMP_BYTES - 1)),
                               data: stamp_flat[(STAMP_BYTES*8-1) - idx*8 -: 8]};
                if (push_ready) begin
                    next_idx = idx + 5'd1;
                    if (idx == 5'(STAMP_BYTES - 1)) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_comb begin
        next_rsp_valid = rsp_valid;
        next_rsp_last  = rsp_last;
        next_rsp_data  = rsp_data;
        if (pop_ready) begin
            next_rsp_valid = pop_valid;
            next_rsp_last  = pop_byte.last;
            next_rsp_data  = pop_byte.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            len       <= '0;
            idx       <= '0;
            append    <= APPEND_RESET;
            stamp     <= '0;
            rsp_valid <= 1'b0;
            rsp_last  <= 1'b0;
            rsp_data  <= '0;
            for (int i = 0; i < MAX_BYTES; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            state     <= next_state;
            len       <= next_len;
            idx       <= next_idx;
            append    <= next_append;
            stamp     <= next_stamp;
            rsp_valid <= next_rsp_valid;
            rsp_last  <= next_rsp_last;
            rsp_data  <= next_rsp_data;
            for (int i = 0; i < MAX_BYTES; i++) begin
                buf_q[i] <= next_buf[i];
            end
        end
    end
endmodule

// [testbench/tcr_host_model.sv]
`timescale 1ns/1ps
module tcr_host_model (
    input  wire logic       clk,
    input  wire logic       rsp_valid,
    input  wire logic       rsp_last,
    input  wire logic [7:0] rsp_data,
    input  wire logic       stall,
    input  wire logic       hold,
    output logic            rsp_ready
);
    logic [8:0] got[$];
    initial rsp_ready = 1'b0;
    // a byte counts only at an edge where ready was high
    always @(posedge clk) begin
        if (rsp_valid === 1'b1 && rsp_ready)
            got.push_back({rsp_last, rsp_data});
    end
    // ready moves on the falling edge, clear of the design's sampling edge
    always @(negedge clk) begin
        rsp_ready <= !hold && (!stall || ($urandom % 3 == 0));
    end
endmodule

// [testbench/tcr_responder_sva.sv]
`timescale 1ns/1ps
module tcr_responder_sva
    import tcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic [7:0]  cmd_arg,
    input wire logic        cmd_ready,
    input wire logic        evt_valid,
    input wire tcr_event_s  evt,
    input wire logic        evt_ready,
    input wire logic        tag_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_last,
    input wire logic [7:0]  rsp_data,
    input wire logic        rsp_ready,
    input wire logic        append_on
);
    default clocking cb @(posedge clk);
    endclocking
    logic       take_set;
    logic       take_get;
    logic       take_evt;
    logic       arg_bit;
    logic [7:0] cls_q;
    assign take_set = cmd_valid && cmd_ready && cmd_word == 16'h0002;
    assign take_get = cmd_valid && cmd_ready && cmd_word == 16'h0003;
    assign take_evt = evt_valid && evt_ready;
    assign arg_bit = cmd_arg[0];
    function automatic logic [7:0] cls(tcr_event_e k);
        if (k <= EV_PROGRESS)
            return 8'h48;
        if (k <= EV_S_ACK)
            return 8'h82;
        return 8'h42;
    endfunction
    // class byte held here since evt may change once taken
    always_ff @(posedge clk) begin
        if (take_evt)
            cls_q <= cls(evt.kind);
    end
    property p_reset_idle;
        !rstn |=> !rsp_valid && !append_on && cmd_ready;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_set_store;
        disable iff (!rstn) take_set |=> append_on == $past(arg_bit);
    endproperty
    a_set_store: assert property (p_set_store) else $error("control not stored");
    property p_store_hold;
        disable iff (!rstn) !take_set |=> $stable(append_on);
    endproperty
    a_store_hold: assert property (p_store_hold) else $error("control changed");
    property p_get_answer;
        disable iff (!rstn) take_get && !rsp_valid |-> ##[1:4] rsp_valid && rsp_data == 8'h00;
    endproperty
    a_get_answer: assert property (p_get_answer) else $error("no get answer");
    property p_set_answer;
        disable iff (!rstn)
        take_set && !rsp_valid |-> ##[1:4] rsp_valid && rsp_data == 8'h00 && !rsp_last;
    endproperty
    a_set_answer: assert property (p_set_answer) else $error("no set answer");
    property p_evt_class;
        disable iff (!rstn) take_evt && !rsp_valid |=> ##[0:3] rsp_valid && rsp_data == cls_q;
    endproperty
    a_evt_class: assert property (p_evt_class) else $error("wrong code class");
    property p_stall_hold;
        disable iff (!rstn)
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("byte lost in stall");
    property p_one_msg;
        disable iff (!rstn) take_set || take_get |=> !cmd_ready && !evt_ready;
    endproperty
    a_one_msg: assert property (p_one_msg) else $error("second request open");
    property p_tag_busy;
        disable iff (!rstn) tag_ready |-> !cmd_ready && !evt_ready;
    endproperty
    a_tag_busy: assert property (p_tag_busy) else $error("tag overlaps request");
endmodule
bind tcr_responder tcr_responder_sva u_sva (
    .clk       (clk),
    .rstn      (rstn),
    .cmd_valid (cmd_valid),
    .cmd_word  (cmd_word),
    .cmd_arg   (cmd_arg),
    .cmd_ready (cmd_ready),
    .evt_valid (evt_valid),
    .evt       (evt),
    .evt_ready (evt_ready),
    .tag_ready (tag_ready),
    .rsp_valid (rsp_valid),
    .rsp_last  (rsp_last),
    .rsp_data  (rsp_data),
    .rsp_ready (rsp_ready),
    .append_on (append_on)
);

// [testbench/test_tag_config_response_stamp.sv]
`timescale 1ns/1ps
module test_tag_config_response_stamp;
    import tcr_pkg::*;
    logic        clk, rstn, cmd_valid, cmd_ready, evt_valid, evt_ready, tag_valid, tag_last;
    logic        tag_ready, rsp_valid, rsp_last, rsp_ready, append_on, stall, hold, ctrl;
    logic [15:0] cmd_word;
    logic [7:0]  cmd_arg, tag_data, rsp_data;
    tcr_event_s  evt;
    tcr_stamp_s  time_now;
    logic [8:0]  exp_q[$];
    int          n_mismatch, total_checks;
    logic [15:0] codes [15] = '{16'h4800, 16'h4801, 16'h8200, 16'h8201, 16'h8203, 16'h8209,
        16'h4200, 16'h4201, 16'h4203, 16'h4204, 16'h4206, 16'h4207, 16'h4208, 16'h420a, 16'h420b};
    int          pay [15] = '{1, 1, 2, 3, 1, 1, 2, 3, 1, 0, 1, 0, 1, 0, 0};
    logic [7:0]  lo_b [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    logic [7:0]  hi_b [7] = '{8'h17, 8'h3b, 8'h3b, 8'h63, 8'h0c, 8'h1f, 8'h63};
    tcr_responder u_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .evt_valid(evt_valid), .evt(evt),
        .evt_ready(evt_ready), .tag_valid(tag_valid), .tag_last(tag_last), .tag_data(tag_data),
        .tag_ready(tag_ready), .time_now(time_now), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
        .rsp_data(rsp_data), .rsp_ready(rsp_ready), .append_on(append_on));
    tcr_host_model u_host (.clk(clk), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
        .rsp_data(rsp_data), .stall(stall), .hold(hold), .rsp_ready(rsp_ready));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
    task automatic chk(string what, logic [15:0] e, logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic put8(logic [7:0] b, logic last);
        exp_q.push_back({last, b});
    endtask
    task automatic put16(logic [15:0] w, logic last);
        put8(w[15:8], 1'b0);
        put8(w[7:0], last);
    endtask
    function automatic logic [7:0] lim(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction
    task automatic drain(string what);
        int i;
        for (i = 0; i < 500 && u_host.got.size() < exp_q.size(); i++)
            @(negedge clk);
        repeat (6) @(negedge clk);
        chk({what, " count"}, 16'(exp_q.size()), 16'(u_host.got.size()));
        for (i = 0; i < exp_q.size() && i < u_host.got.size(); i++)
            chk(what, 16'(exp_q[i]), 16'(u_host.got[i]));
        exp_q.delete();
        u_host.got.delete();
        $display("test %s done", what);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 500 && cmd_ready !== 1'b1; i++)
            @(negedge clk);
    endtask
    task automatic send_cmd(logic [15:0] w, logic [7:0] a);
        wait_idle();
        cmd_word = w;
        cmd_arg = a;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        put16(w, w != 16'h0003);
        if (w == 16'h0002)
            ctrl = a[0];
        if (w == 16'h0003)
            put8({7'h00, ctrl}, 1'b1);
    endtask
    task automatic send_evt(int k, logic [15:0] a, logic [15:0] b);
        int i;
        for (i = 0; i < 500 && evt_ready !== 1'b1; i++)
            @(negedge clk);
        evt = '{tcr_event_e'(k), a, b};
        evt_valid = 1'b1;
        @(negedge clk);
        evt_valid = 1'b0;
        put16(codes[k], pay[k] == 0);
        if (pay[k] == 1)
            put16(a, 1'b1);
        if (pay[k] == 2) begin
            put16(a, 1'b0);
            put16(b, 1'b1);
        end
        if (pay[k] == 3) begin
            put8(a[7:0], 1'b0);
            put8(b[7:0], 1'b1);
        end
    endtask
    // time_now moves after the first byte; the stamp must not follow it
    task automatic send_tag(int n, tcr_stamp_s st);
        int i;
        int j;
        logic [7:0] b;
        bit ok;
        wait_idle();
        time_now = st;
        for (i = 0; i < n; i++) begin
            b = 8'($urandom);
            tag_data = b;
            tag_last = (i == n - 1);
            tag_valid = 1'b1;
            for (j = 0; j < 500; j++) begin
                ok = (tag_ready === 1'b1);
                @(negedge clk);
                if (ok)
                    break;
            end
            time_now = tcr_stamp_s'({$urandom, $urandom});
            put8(b, tag_last && !ctrl);
        end
        tag_valid = 1'b0;
        for (i = 0; i < 7 && ctrl; i++)
            put8(lim(st[55 - 8 * i -: 8], lo_b[i], hi_b[i]), i == 6);
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        ctrl = 1'b0;
    endtask
    initial begin
        {rstn, cmd_valid, evt_valid, tag_valid, tag_last, stall, hold, ctrl} = 8'h00;
        {cmd_word, cmd_arg, tag_data} = 32'h0000_0000;
        evt = '0;
        time_now = '0;
        n_mismatch = 0;
        total_checks = 0;
        void'($urandom(29562));
        do_reset();
        chk("append_on reset", 16'h0000, 16'(append_on));
        chk("cmd_ready reset", 16'h0001, 16'(cmd_ready));
        send_cmd(16'h0003, 8'h00);
        send_tag(5, '1);
        drain("default");
        send_cmd(16'h0002, 8'hfd);
        chk("append_on set", 16'h0001, 16'(append_on));
        send_cmd(16'h0003, 8'h5a);
        drain("set get");
        stall = 1'b1;
        send_tag(3, 56'h17_3b_3b_63_0c_1f_63);
        send_tag(4, 56'h00_00_00_00_01_01_00);
        send_tag(6, tcr_stamp_s'({$urandom, $urandom}));
        drain("stamps");
        hold = 1'b1;
        fork
            send_tag(12, tcr_stamp_s'({$urandom, $urandom}));
            begin
                repeat (40) @(negedge clk);
                chk("tag_ready full", 16'h0000, 16'(tag_ready));
                hold = 1'b0;
            end
        join
        drain("full buffer");
        send_cmd(16'h0002, 8'h00);
        send_cmd(16'h1234, 8'h00);
        send_tag(3, '1);
        drain("disable");
        for (int k = 0; k < 2; k++)
            send_evt(k, 16'($urandom), 16'($urandom));
        for (int k = 2; k < 6; k++)
            send_evt(k, 16'($urandom), 16'($urandom));
        for (int k = 6; k < 15; k++)
            send_evt(k, 16'($urandom), 16'($urandom));
        drain("events");
        send_cmd(16'h0002, 8'h01);
        drain("set again");
        do_reset();
        chk("append_on reset", 16'h0000, 16'(append_on));
        send_cmd(16'h0003, 8'h00);
        drain("second reset");
        results();
    end
endmodule
